// file: include/anap_params.svh
// anap_params.svh: constants for the arbitration and next page block
// assumes inclusion by bare name; definitions only
`ifndef ANAP_PARAMS_SVH
`define ANAP_PARAMS_SVH

// -------------------------------------------------------------------
// register offsets
// -------------------------------------------------------------------
`define ANAP_OFF_CTRL 4'h0
`define ANAP_OFF_ABIL 4'h1
`define ANAP_OFF_STAT 4'h2
`define ANAP_OFF_IRQ 4'h3
`define ANAP_OFF_MASK 4'h4
`define ANAP_OFF_NPTX 4'h5
`define ANAP_OFF_LPBASE 4'h6
`define ANAP_OFF_LPNP 4'h7

// -------------------------------------------------------------------
// field positions and codes
// -------------------------------------------------------------------
`define ANAP_BIT_NP 15
`define ANAP_BIT_ACK 14
`define ANAP_BIT_MP 13
`define ANAP_BIT_ACK2 12
`define ANAP_BIT_TOG 11
`define ANAP_NULL_CODE 11'h001
`define ANAP_TA_LSB 5
`define ANAP_TA_10 0
`define ANAP_TA_10FD 1
`define ANAP_TA_TX 2
`define ANAP_TA_TXFD 3
`define ANAP_TA_T4 4

// -------------------------------------------------------------------
// reset values
// -------------------------------------------------------------------
`define ANAP_RST_CTRL 16'h0001
`define ANAP_RST_ABIL 16'h01E1
`define ANAP_RST_WORD 16'h0000
`define ANAP_RST_IRQ 8'h00

`endif

// file: include/anap_pkg.sv
// anap_pkg.sv: types for the arbitration and next page block
// assumes anap_params.svh is on the include path
package anap_pkg;
  // resolved technology, one-hot
  typedef enum logic [5:0] {
    ANAP_HCD_NONE = 6'h01,
    ANAP_HCD_10 = 6'h02,
    ANAP_HCD_10FD = 6'h04,
    ANAP_HCD_TX = 6'h08,
    ANAP_HCD_T4 = 6'h10,
    ANAP_HCD_TXFD = 6'h20
  } anap_hcd_t;

  // arbitration states, one-hot
  typedef enum logic [4:0] {
    ANAP_ST_IDLE = 5'h01,
    ANAP_ST_NEG = 5'h02,
    ANAP_ST_NP = 5'h04,
    ANAP_ST_LINK = 5'h08,
    ANAP_ST_REFUSE = 5'h10
  } anap_state_t;

  // a received page from the FLP receive logic
  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } anap_page_t;
endpackage : anap_pkg

// file: design/anap_arb.sv
// anap_arb.sv: auto-negotiation arbitration, resolution and next pages
// assumes FLP transmit/receive logic that sends the word on o_tx_page
// with base page timing, and reports consistent, acked pages
//
// Functional notes
// - parallel detect a fixed 100Base-T4 partner, even before FLP seen
// - with T4 PMA enable it and link; without it refuse any link
// - resolve best common technology after base page exchange completes
// - correct resolution for all combinations of five ability bits
// - full duplex chosen over half duplex of the same speed when both sides offer it
// - link only when a common technology exists, else refuse
// - link fail from resolved technology restarts negotiation
// - both offering next page: each sends at least one next page
// - next pages go out with the same burst timing as base page
// - next pages get the same consistency match as base pages
// - mismatch after ack detect stops next page sending at once
// - after own pages, send null pages until partner is done
// - null page is message page with code value one
// - null code never sent before all real pages are sent
// - null pages carry next page bit zero
// - next page bit one while more pages follow, zero on last
// - first toggle inverts own base D11, then alternates each page
`include "anap_params.svh"
`timescale 1ns/1ps
`default_nettype none

module anap_arb
  import anap_pkg::*;
#(
  parameter bit HAS_T4 = 1'b1
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_irq,
  input wire logic i_t4_detect,
  input wire logic i_link_fail,
  input wire anap_page_t i_rx_page,
  input wire logic i_rx_inconsistent,
  input wire logic i_exch_done,
  input wire logic i_page_sent,
  output logic [15:0] o_tx_page,
  output logic o_tx_en,
  output logic o_restart,
  output logic o_link_up,
  output logic [5:0] o_hcd
);

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic [1:0] t4_sync_reg;
  logic [1:0] fail_sync_reg;
  logic t4_det;
  logic link_fail;

  // two stages each; only the second stage is looked at
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      t4_sync_reg <= 2'h0;
      fail_sync_reg <= 2'h0;
    end else begin
      t4_sync_reg <= {t4_sync_reg[0], i_t4_detect};
      fail_sync_reg <= {fail_sync_reg[0], i_link_fail};
    end
  end
  assign t4_det = t4_sync_reg[1];
  assign link_fail = fail_sync_reg[1];

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic [15:0] ctrl_reg;
  logic [15:0] abil_reg;
  logic [15:0] nptx_reg;
  logic nptx_pend_reg;
  logic [15:0] lpbase_reg;
  logic [15:0] lpnp_reg;
  logic [7:0] irq_reg;
  logic [7:0] irq_next;
  logic [7:0] mask_reg;
  logic [15:0] rdata_reg;
  anap_state_t state_reg;
  anap_hcd_t hcd_reg;
  logic tog_reg;
  logic own_done_reg;
  logic lp_done_reg;
  logic np_stop_reg;
  logic tx_hold_reg;
  logic [7:0] ev;

  // resolution: walk the priority list, best first
  function automatic anap_hcd_t resolve(input logic [4:0] a);
    if (a[`ANAP_TA_TXFD]) resolve = ANAP_HCD_TXFD;
    else if (a[`ANAP_TA_T4]) resolve = ANAP_HCD_T4;
    else if (a[`ANAP_TA_TX]) resolve = ANAP_HCD_TX;
    else if (a[`ANAP_TA_10FD]) resolve = ANAP_HCD_10FD;
    else if (a[`ANAP_TA_10]) resolve = ANAP_HCD_10;
    else resolve = ANAP_HCD_NONE;
  endfunction

  logic [4:0] common;
  anap_hcd_t hcd_calc;
  logic both_np;
  logic rx_np_valid;
  logic [15:0] null_page;

  // common abilities over every combination of the five bits
  assign common = abil_reg[`ANAP_TA_LSB +: 5] & lpbase_reg[`ANAP_TA_LSB +: 5];
  assign hcd_calc = resolve(common);
  assign both_np = abil_reg[`ANAP_BIT_NP] & lpbase_reg[`ANAP_BIT_NP];
  assign rx_np_valid = i_rx_page.valid && state_reg == ANAP_ST_NP;
  // message page, np clear, code one
  assign null_page = {1'b0, 1'b0, 1'b1, 1'b0, tog_reg,
                      `ANAP_NULL_CODE};

  // -----------------------------------------------------------------
  // arbitration state machine
  // -----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= ANAP_ST_IDLE;
      hcd_reg <= ANAP_HCD_NONE;
    end else begin
      unique case (state_reg)
        ANAP_ST_IDLE: begin
          if (ctrl_reg[0]) state_reg <= ANAP_ST_NEG;
        end
        ANAP_ST_NEG: begin
          // parallel detection beats FLP; it needs no base page at all
          if (t4_det) begin
            hcd_reg <= HAS_T4 ? ANAP_HCD_T4 : ANAP_HCD_NONE;
            state_reg <= HAS_T4 ? ANAP_ST_LINK : ANAP_ST_REFUSE;
          end else if (i_exch_done) begin
            hcd_reg <= hcd_calc;
            if (both_np) state_reg <= ANAP_ST_NP;
            else if (hcd_calc == ANAP_HCD_NONE)
              state_reg <= ANAP_ST_REFUSE;
            else state_reg <= ANAP_ST_LINK;
          end
        end
        ANAP_ST_NP: begin
          if (np_stop_reg) state_reg <= ANAP_ST_REFUSE;
          else if (own_done_reg && lp_done_reg) begin
            state_reg <= (hcd_reg == ANAP_HCD_NONE) ? ANAP_ST_REFUSE
                                                     : ANAP_ST_LINK;
          end
        end
        ANAP_ST_LINK: begin
          if (link_fail) state_reg <= ANAP_ST_NEG;
        end
        ANAP_ST_REFUSE: begin
          // stays down until software restarts
          if (ctrl_reg[1]) state_reg <= ANAP_ST_NEG;
        end
      endcase
      if (ctrl_reg[1]) state_reg <= ANAP_ST_NEG;
      if (!ctrl_reg[0]) state_reg <= ANAP_ST_IDLE;
    end
  end

  // -----------------------------------------------------------------
  // next page transmit
  // -----------------------------------------------------------------
  // pages are handed to the same FLP sender as the base page, so burst
  // timing cannot differ between them
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      tog_reg <= 1'b0;
      own_done_reg <= 1'b0;
      lp_done_reg <= 1'b0;
      np_stop_reg <= 1'b0;
      nptx_pend_reg <= 1'b0;
    end else begin
      if (i_wr && i_addr == `ANAP_OFF_NPTX) nptx_pend_reg <= 1'b1;
      if (state_reg != ANAP_ST_NP) begin
        tog_reg <= ~abil_reg[`ANAP_BIT_TOG];
        own_done_reg <= 1'b0;
        lp_done_reg <= 1'b0;
        np_stop_reg <= 1'b0;
      end else begin
        if (i_rx_inconsistent) np_stop_reg <= 1'b1;
        if (rx_np_valid && !i_rx_page.word[`ANAP_BIT_NP])
          lp_done_reg <= 1'b1;
        if (i_page_sent) begin
          tog_reg <= ~tog_reg;
          if (!own_done_reg) begin
            nptx_pend_reg <= 1'b0;
            // last real page has np clear
            if (!nptx_reg[`ANAP_BIT_NP]) own_done_reg <= 1'b1;
          end
        end
      end
    end
  end

  // the outgoing word is a flop behind its sources, so the sender is held
  // for one cycle after any new page, toggle flip or entry into the next page state;
  // without it the sender could start on a stale word
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_hold_reg <= 1'b1;
    end else begin
      tx_hold_reg <= (state_reg != ANAP_ST_NP) || i_page_sent ||
                     (i_wr && i_addr == `ANAP_OFF_NPTX);
    end
  end

  // outgoing word; null only once own pages are finished
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_tx_page <= `ANAP_RST_WORD;
    end else if (state_reg != ANAP_ST_NP) begin
      o_tx_page <= abil_reg;
    end else if (own_done_reg) begin
      o_tx_page <= null_page;
    end else begin
      o_tx_page <= {nptx_reg[15:12], tog_reg, nptx_reg[10:0]};
    end
  end

  // a real page that has not been loaded yet holds the sender
  assign o_tx_en = (state_reg == ANAP_ST_NEG) ||
                   (state_reg == ANAP_ST_NP && !np_stop_reg && !tx_hold_reg &&
                    (own_done_reg || nptx_pend_reg));
  assign o_restart = (state_reg == ANAP_ST_LINK) && link_fail;
  assign o_link_up = (state_reg == ANAP_ST_LINK);
  assign o_hcd = hcd_reg;

  // -----------------------------------------------------------------
  // register file and interrupts
  // -----------------------------------------------------------------
  // bit1 t4 refused, 2 restart, 3 np received, 4 np mismatch;
  // bit0 (exchange complete) is folded in with the sticky update below
  assign ev = {3'h0, state_reg == ANAP_ST_NP && i_rx_inconsistent,
               rx_np_valid, o_restart,
               state_reg == ANAP_ST_NEG && t4_det && !HAS_T4, 1'b0};

  // software writes; restart bit self clears
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_reg <= `ANAP_RST_CTRL;
      abil_reg <= `ANAP_RST_ABIL;
      nptx_reg <= `ANAP_RST_WORD;
      mask_reg <= `ANAP_RST_IRQ;
    end else begin
      ctrl_reg[1] <= 1'b0;
      if (i_wr) begin
        unique case (i_addr)
          `ANAP_OFF_CTRL: ctrl_reg <= i_wdata;
          `ANAP_OFF_ABIL: abil_reg <= i_wdata;
          `ANAP_OFF_NPTX: nptx_reg <= i_wdata;
          `ANAP_OFF_MASK: mask_reg <= i_wdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // partner words captured from the receive side
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      lpbase_reg <= `ANAP_RST_WORD;
      lpnp_reg <= `ANAP_RST_WORD;
    end else if (i_rx_page.valid) begin
      if (state_reg == ANAP_ST_NEG) lpbase_reg <= i_rx_page.word;
      else if (state_reg == ANAP_ST_NP) lpnp_reg <= i_rx_page.word;
    end
  end

  // sticky status; set wins over clear by read
  always_comb begin
    irq_next = irq_reg;
    if (i_rd && i_addr == `ANAP_OFF_IRQ) irq_next = 8'h00;
    irq_next = irq_next | ev;
    irq_next[0] = irq_next[0] | (state_reg == ANAP_ST_NP && own_done_reg
                                 && lp_done_reg);
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) irq_reg <= `ANAP_RST_IRQ;
    else irq_reg <= irq_next;
  end
  assign o_irq = |(irq_reg & mask_reg);

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_reg <= 16'h0000;
    end else if (i_rd) begin
      unique case (i_addr)
        `ANAP_OFF_CTRL: rdata_reg <= ctrl_reg;
        `ANAP_OFF_ABIL: rdata_reg <= abil_reg;
        `ANAP_OFF_STAT: rdata_reg <= {5'h00, state_reg, o_hcd};
        `ANAP_OFF_IRQ: rdata_reg <= {8'h00, irq_reg};
        `ANAP_OFF_MASK: rdata_reg <= {8'h00, mask_reg};
        `ANAP_OFF_NPTX: rdata_reg <= nptx_reg;
        `ANAP_OFF_LPBASE: rdata_reg <= lpbase_reg;
        `ANAP_OFF_LPNP: rdata_reg <= lpnp_reg;
        default: rdata_reg <= 16'h0000;
      endcase
    end else begin
      rdata_reg <= 16'h0000;
    end
  end
  assign o_rdata = rdata_reg;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  a_t4_refuse: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    state_reg == ANAP_ST_NEG && t4_det && !ctrl_reg[1] && ctrl_reg[0]
    |=> o_link_up == HAS_T4)
    else $error("t4 parallel detect handled wrong");
  a_no_common: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_link_up |-> hcd_reg != ANAP_HCD_NONE)
    else $error("link up without common technology");
  a_fail_restart: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_link_up && link_fail && ctrl_reg[0] |=> state_reg == ANAP_ST_NEG)
    else $error("link fail did not restart");
  a_null_np: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_tx_page[10:0] == `ANAP_NULL_CODE && o_tx_page[`ANAP_BIT_MP]
    && $past(own_done_reg) |-> !o_tx_page[`ANAP_BIT_NP])
    else $error("null page with np set");
  a_null_late: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $past(state_reg) == ANAP_ST_NP && !$past(own_done_reg)
    |-> o_tx_page != null_page || nptx_reg[10:0] == `ANAP_NULL_CODE)
    else $error("null page sent early");
  a_tog_flip: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    state_reg == ANAP_ST_NP && i_page_sent ##1 state_reg == ANAP_ST_NP
    |-> tog_reg != $past(tog_reg))
    else $error("toggle did not alternate");
  a_np_stop: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    state_reg == ANAP_ST_NP && i_rx_inconsistent |=> !o_tx_en)
    else $error("next pages continued after mismatch");
  a_np_end: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $past(state_reg) == ANAP_ST_NP && o_link_up
    |-> $past(own_done_reg) && $past(lp_done_reg))
    else $error("exchange ended early");

endmodule // anap_arb

`default_nettype wire

// file: tb/anap_lp_model.sv
// anap_lp_model.sv: link partner negotiation logic, page level
// assumes one clock; the bench loads pages and raises i_run
`timescale 1ns/1ps
`default_nettype none
module anap_lp_model (
  input wire logic i_mclk,
  input wire logic i_run,
  input wire logic i_tx_en,
  output var anap_pkg::anap_page_t o_rx_page,
  output logic o_page_sent
);
  logic [15:0] pages[$];
  // ------------------------------------
  // page delivery
  // ------------------------------------
  // a released word shows its inverse so stale data never passes
  task automatic send_page(input logic [15:0] w);
    o_rx_page <= {1'b1, w};
    @(posedge i_mclk);
    o_rx_page <= {1'b0, ~w};
  endtask
  // answer each sent page with our next one, promptly or slowly
  initial begin
    o_rx_page = '0;
    o_page_sent = 1'b0;
    forever begin
      @(posedge i_mclk);
      if (i_run && i_tx_en) begin
        repeat ($urandom_range(4, 1)) @(posedge i_mclk);
        if (i_tx_en) begin
          o_page_sent <= 1'b1;
          @(posedge i_mclk);
          o_page_sent <= 1'b0;
          if (pages.size() != 0) send_page(pages.pop_front());
          repeat (6) @(posedge i_mclk);
        end
      end
    end
  end
endmodule // anap_lp_model
`default_nettype wire

// file: tb/anap_arb_tb.sv
// anap_arb_tb.sv: self-checking bench for the arbitration block
// assumes anap_pkg compiled first, anap_params.svh on include path
`include "anap_params.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
`define WAITC(c) for (int n = 0; !(c); n++) begin \
  if (n == 300) begin num_errors++; end_of_test; end idle(1); end
module anap_arb_tb;
  import anap_pkg::*;
  logic i_mclk, i_rstn, i_wr, i_rd, i_t4_detect, i_link_fail;
  logic i_rx_inconsistent, i_exch_done, lp_run, i_page_sent, nt4_link;
  logic o_irq, o_tx_en, o_restart, o_link_up;
  logic [3:0] i_addr;
  logic [15:0] i_wdata, o_rdata, o_tx_page;
  logic [5:0] o_hcd;
  anap_page_t i_rx_page;
  logic [15:0] exp_rd[$], msk_rd[$], exp_tx[$];
  int num_errors = 0;
  int checks = 0;
  logic rd_pend = 1'b0;
  anap_arb dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_irq(o_irq), .i_t4_detect(i_t4_detect), .i_link_fail(i_link_fail),
    .i_rx_page(i_rx_page), .i_rx_inconsistent(i_rx_inconsistent),
    .i_exch_done(i_exch_done), .i_page_sent(i_page_sent),
    .o_tx_page(o_tx_page), .o_tx_en(o_tx_en), .o_restart(o_restart),
    .o_link_up(o_link_up), .o_hcd(o_hcd));
  // same stimulus into a build without the T4 PMA
  anap_arb #(.HAS_T4(1'b0)) dut_nt4 (.*, .o_rdata(), .o_irq(),
    .o_tx_page(), .o_tx_en(), .o_restart(), .o_link_up(nt4_link),
    .o_hcd());
  anap_lp_model lp (.i_mclk(i_mclk), .i_run(lp_run), .i_tx_en(o_tx_en),
    .o_rx_page(i_rx_page), .o_page_sent(i_page_sent));
  // ------------------------------------
  // clock and result monitor
  // ------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  // judged mid-cycle so no edge update races the compare
  always @(negedge i_mclk) begin
    logic [15:0] e, m;
    if (rd_pend) begin
      m = msk_rd.pop_front();
      e = exp_rd.pop_front();
      `CHK(o_rdata & m, e)
    end
    if (i_page_sent) begin
      e = exp_tx.pop_front();
      `CHK(o_tx_page, e)
    end
    rd_pend = i_rd;
  end
  // ------------------------------------
  // tasks
  // ------------------------------------
  // strobes are held between back-to-back accesses, dropped by idle
  task automatic idle(input int n);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    i_rd <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e,
    input logic [15:0] m);
    exp_rd.push_back(e & m);
    msk_rd.push_back(m);
    i_addr <= a;
    i_rd <= 1'b1;
    i_wr <= 1'b0;
    @(posedge i_mclk);
  endtask
  // partner base word, then the exchange completes; the first idle lets a
  // pending restart land, as the word is only captured in negotiation
  task automatic base(input logic [15:0] w);
    idle(1);
    lp.send_page(w);
    `CHK(o_link_up, 1'b0);
    i_exch_done <= 1'b1;
    idle(1);
    i_exch_done <= 1'b0;
    idle(2);
  endtask
  function automatic logic [5:0] hcd_of(input logic [4:0] c);
    if (c[`ANAP_TA_TXFD]) return ANAP_HCD_TXFD;
    if (c[`ANAP_TA_T4]) return ANAP_HCD_T4;
    if (c[`ANAP_TA_TX]) return ANAP_HCD_TX;
    if (c[`ANAP_TA_10FD]) return ANAP_HCD_10FD;
    if (c[`ANAP_TA_10]) return ANAP_HCD_10;
    return ANAP_HCD_NONE;
  endfunction
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ------------------------------------
  // main sequence
  // ------------------------------------
  initial begin
    logic [4:0] own, st;
    logic [5:0] h;
    i_rstn = 1'b0;
    {i_wr, i_rd, i_t4_detect, i_link_fail} = '0;
    {i_rx_inconsistent, i_exch_done, lp_run} = '0;
    i_addr = '0;
    i_wdata = '0;
    void'($urandom(32'hBDF1));
    repeat (3) @(posedge i_mclk);
    i_rstn <= 1'b1;
    rd(`ANAP_OFF_CTRL, `ANAP_RST_CTRL, 16'hFFFF);
    rd(`ANAP_OFF_ABIL, `ANAP_RST_ABIL, 16'hFFFF);
    rd(`ANAP_OFF_STAT, 16'({ANAP_ST_NEG, ANAP_HCD_NONE}), 16'hFFFF);
    rd(4'h9, 16'h0000, 16'hFFFF);
    // every partner ability combination against random own abilities
    for (int c = 0; c < 32; c++) begin
      own = 5'($urandom);
      h = hcd_of(own & 5'(c));
      st = (h != ANAP_HCD_NONE) ? ANAP_ST_LINK : ANAP_ST_REFUSE;
      wr(`ANAP_OFF_ABIL, {6'h00, own, 5'h01});
      wr(`ANAP_OFF_CTRL, 16'h0003);
      base({6'h00, 5'(c), 5'h01});
      `CHK(o_hcd, h);
      `CHK(o_link_up, h != ANAP_HCD_NONE);
      rd(`ANAP_OFF_STAT, 16'({st, h}), 16'hFFFF);
    end
    // fixed T4 partner, no bursts seen
    wr(`ANAP_OFF_CTRL, 16'h0003);
    i_t4_detect <= 1'b1;
    idle(4);
    `CHK(o_link_up, 1'b1);
    `CHK(o_hcd, ANAP_HCD_T4);
    `CHK(nt4_link, 1'b0);
    i_t4_detect <= 1'b0;
    wr(`ANAP_OFF_MASK, 16'h0000);
    rd(`ANAP_OFF_IRQ, 16'h0000, 16'hFFFF);
    // link failure restarts; its interrupt is masked, then unmasked
    i_link_fail <= 1'b1;
    `WAITC(o_restart === 1'b1)
    idle(2);
    `CHK(o_link_up, 1'b0);
    rd(`ANAP_OFF_STAT, 16'(ANAP_ST_NEG) << 6, 16'h07C0);
    i_link_fail <= 1'b0;
    `CHK(o_irq, 1'b0);
    wr(`ANAP_OFF_MASK, 16'h0004);
    idle(2);
    `CHK(o_irq, 1'b1);
    rd(`ANAP_OFF_IRQ, 16'h0004, 16'hFFFF);
    idle(2);
    `CHK(o_irq, 1'b0);
    // next pages: two own, partner has four, so two nulls follow
    wr(`ANAP_OFF_ABIL, 16'h89E1);
    wr(`ANAP_OFF_CTRL, 16'h0003);
    lp.pages = '{16'hA805, 16'h8123, 16'hA807, 16'h0456};
    exp_tx = '{16'hA005, 16'h2806, 16'h2001, 16'h2801};
    base(16'h81E1);
    lp_run <= 1'b1;
    wr(`ANAP_OFF_NPTX, 16'hA005);
    `WAITC(i_page_sent === 1'b1)
    wr(`ANAP_OFF_NPTX, 16'h2006);
    `WAITC(o_link_up === 1'b1)
    lp_run <= 1'b0;
    `CHK(o_hcd, ANAP_HCD_TXFD);
    `CHK(exp_tx.size(), 0);
    rd(`ANAP_OFF_LPBASE, 16'h81E1, 16'hFFFF);
    rd(`ANAP_OFF_LPNP, 16'h0456, 16'hFFFF);
    // inconsistent page mid exchange stops sending at once
    wr(`ANAP_OFF_CTRL, 16'h0003);
    base(16'h81E1);
    wr(`ANAP_OFF_NPTX, 16'hA005);
    idle(1);
    `WAITC(o_tx_en === 1'b1)
    i_rx_inconsistent <= 1'b1;
    idle(1);
    i_rx_inconsistent <= 1'b0;
    idle(1);
    `CHK(o_tx_en, 1'b0);
    `CHK(o_link_up, 1'b0);
    // exchange complete, pages received and the mismatch are all pending
    rd(`ANAP_OFF_IRQ, 16'h0019, 16'h001F);
    // disabling negotiation parks the block and silences the sender
    wr(`ANAP_OFF_CTRL, 16'h0000);
    idle(1);
    rd(`ANAP_OFF_STAT, 16'(ANAP_ST_IDLE) << 6, 16'h07C0);
    `CHK(o_tx_en, 1'b0);
    idle(2);
    end_of_test;
  end
endmodule // anap_arb_tb
`default_nettype wire
